// ===== logic/pwr_seq_pkg.sv
package pwr_seq_pkg;
	// Clock rate in kHz
	localparam int CLK_KHZ = 10000;
	// Least lead of external_clear_n before standby falls, in states
	localparam int RAM_HOLD_STATES = 10;
	// Recovery lead before standby rises, in ns
	localparam int RECOVER_LEAD_NS = 100;
	localparam int RECOVER_LEAD_CYC =
		(RECOVER_LEAD_NS * CLK_KHZ + 999999) / 1000000;
	localparam logic [3:0] HOLD_CNT_MAX = 4'hA;
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_MANUAL,
		ST_POR,
		ST_EXC,
		ST_RUN
	} seq_state_t;
endpackage : pwr_seq_pkg

// ===== logic/powerup_standby_reset_sequencer.sv
`timescale 1ns/10ps
module powerup_standby_reset_sequencer
	import pwr_seq_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic hw_standby_n_i,
	input wire logic nmi_i,
	input wire logic external_clear_n_i,
	input wire logic onchip_ram_enable_i,
	output logic osc_enable_o,
	output logic pins_hiz_o,
	output logic pins_undefined_o,
	output logic manual_reset_o,
	output logic por_reset_o,
	output logic exc_start_o,
	output logic ram_retain_o,
	output logic [2:0] state_o
);
	typedef struct packed {
		logic [2:0] hw_standby_n_sync;
		logic [2:0] nmi_sync;
		logic [2:0] clr_sync;
		logic hw_standby_n_f;
		logic nmi_f;
		logic clr_f;
		logic nmi_seen_low;
		logic [3:0] clr_cnt;
		logic retain;
		logic exc;
		seq_state_t st;
	} state_t;

	state_t s_reg;
	state_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.exc = 1'b0;
		s_next.hw_standby_n_sync = {s_reg.hw_standby_n_sync[1:0], hw_standby_n_i};
		s_next.nmi_sync = {s_reg.nmi_sync[1:0], nmi_i};
		s_next.clr_sync = {s_reg.clr_sync[1:0], external_clear_n_i};
		// Accept a level only when stages two and three agree
		if (s_reg.hw_standby_n_sync[2] == s_reg.hw_standby_n_sync[1]) begin
			s_next.hw_standby_n_f = s_reg.hw_standby_n_sync[2];
		end
		if (s_reg.nmi_sync[2] == s_reg.nmi_sync[1]) begin
			s_next.nmi_f = s_reg.nmi_sync[2];
		end
		if (s_reg.clr_sync[2] == s_reg.clr_sync[1]) begin
			s_next.clr_f = s_reg.clr_sync[2];
		end
		// Count states that clear has been low, for RAM retention
		if (s_reg.clr_f) begin
			s_next.clr_cnt = 4'h0;
		end else if (s_reg.clr_cnt != HOLD_CNT_MAX) begin
			s_next.clr_cnt = s_reg.clr_cnt + 4'h1;
		end
		if (!s_reg.nmi_f) begin
			s_next.nmi_seen_low = 1'b1;
		end
		if (!s_reg.hw_standby_n_f) begin
			if (s_reg.st != ST_STANDBY) begin
				// Retention only when clear led standby long enough
				// Clear may rise as standby falls, so only the lead counts
				s_next.retain = onchip_ram_enable_i &&
					(s_reg.clr_cnt == HOLD_CNT_MAX);
			end
			s_next.st = ST_STANDBY;
		end else begin
			unique case (s_reg.st)
				ST_STANDBY: begin
					s_next.st = ST_POR;
				end
				ST_MANUAL: begin
					if (s_reg.nmi_f) begin
						s_next.st = ST_POR;
					end
				end
				ST_POR: begin
					if (s_reg.clr_f) begin
						s_next.st = ST_EXC;
						s_next.exc = 1'b1;
					end
				end
				ST_EXC: begin
					s_next.st = ST_RUN;
					s_next.retain = 1'b0;
				end
				ST_RUN: begin
					if (!s_reg.clr_f) begin
						s_next.st = ST_POR;
					end
				end
				default: begin
					s_next.st = ST_MANUAL;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			s_reg <= '0;
			// Assume standby high until the filter proves otherwise
			s_reg.hw_standby_n_sync <= 3'h7;
			s_reg.hw_standby_n_f <= 1'b1;
			s_reg.st <= ST_MANUAL;
		end else begin
			s_reg <= s_next;
		end
	end

	assign osc_enable_o = (s_reg.st != ST_STANDBY);
	assign pins_hiz_o = (s_reg.st == ST_STANDBY);
	assign pins_undefined_o = (s_reg.st == ST_MANUAL);
	assign manual_reset_o = (s_reg.st == ST_MANUAL);
	assign por_reset_o = (s_reg.st == ST_POR);
	assign exc_start_o = s_reg.exc;
	assign ram_retain_o = s_reg.retain;
	assign state_o = s_reg.st;

	sequence hw_standby_n_low_seen;
		!s_reg.hw_standby_n_f;
	endsequence

	a_standby_entry: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		hw_standby_n_low_seen |=> s_reg.st == ST_STANDBY)
		else $error("standby not entered");
	a_standby_exit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_STANDBY && s_reg.hw_standby_n_f |=> s_reg.st == ST_POR)
		else $error("standby exit not to power-on reset");
	a_hiz_standby: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		pins_hiz_o == (s_reg.st == ST_STANDBY))
		else $error("pins not high-impedance in standby");
	a_osc_stopped: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_STANDBY |-> !osc_enable_o)
		else $error("oscillator runs in standby");
	a_nmi_release: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_MANUAL && s_reg.hw_standby_n_f && s_reg.nmi_f
		|=> s_reg.st == ST_POR)
		else $error("high interrupt pin did not leave manual reset");
	a_manual_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_MANUAL && !s_reg.nmi_f |=>
		s_reg.st inside {ST_MANUAL, ST_STANDBY})
		else $error("manual reset left while interrupt pin low");
	a_undef_manual: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		pins_undefined_o |-> manual_reset_o && !pins_hiz_o)
		else $error("undefined pin flag outside manual reset");
	a_exc_start: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_POR && s_reg.clr_f && s_reg.hw_standby_n_f
		|=> exc_start_o ##1 !exc_start_o)
		else $error("exception handling not started once");
	a_glitch_filter: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$changed(s_reg.hw_standby_n_f) |->
		$past(s_reg.hw_standby_n_sync[2]) == $past(s_reg.hw_standby_n_sync[1]))
		else $error("standby level taken without agreement");
	a_retain_rule: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(ram_retain_o) |-> $past(s_reg.clr_cnt) == HOLD_CNT_MAX)
		else $error("retention without clear lead");

	sequence exc_one_pulse;
		exc_start_o ##1 !exc_start_o;
	endsequence

	sequence hw_standby_n_high_seen;
		s_reg.hw_standby_n_f;
	endsequence

	a_exc_pulse: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(exc_start_o) |-> exc_one_pulse)
		else $error("exception start longer than one cycle");
	a_exc_state: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		exc_start_o |-> s_reg.st == ST_EXC)
		else $error("exception start outside exception state");
	a_exc_to_run: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_EXC && hw_standby_n_high_seen |=> s_reg.st == ST_RUN)
		else $error("exception state did not lead to run");
	a_osc_running: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st != ST_STANDBY |-> osc_enable_o)
		else $error("oscillator stopped outside standby");
	a_osc_start: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(osc_enable_o) |-> $past(s_reg.hw_standby_n_f))
		else $error("oscillator started without standby high");
	a_hiz_exclusive: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		pins_hiz_o |-> !pins_undefined_o && !manual_reset_o)
		else $error("high-impedance overlaps manual reset");
	a_manual_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		manual_reset_o == (s_reg.st == ST_MANUAL))
		else $error("manual reset flag wrong");
	a_manual_only_rst: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st != ST_MANUAL |=> s_reg.st != ST_MANUAL)
		else $error("manual reset entered without reset");
	a_por_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		por_reset_o == (s_reg.st == ST_POR))
		else $error("power-on reset flag wrong");
	a_por_after_hw_standby_n: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$fell(pins_hiz_o) |-> s_reg.st == ST_POR)
		else $error("standby left to a state other than power-on reset");
	a_hw_standby_n_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$changed(s_reg.hw_standby_n_f) |-> s_reg.hw_standby_n_f == $past(s_reg.hw_standby_n_sync[2]))
		else $error("standby level not taken from last stage");
	a_nmi_filter: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$changed(s_reg.nmi_f) |->
		$past(s_reg.nmi_sync[2]) == $past(s_reg.nmi_sync[1]))
		else $error("interrupt level taken without agreement");
	a_retain_enable: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(ram_retain_o) |-> $past(onchip_ram_enable_i))
		else $error("retention flagged with RAM disabled");
	a_retain_hw_standby_n: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(ram_retain_o) |-> s_reg.st == ST_STANDBY)
		else $error("retention flagged outside standby");
	a_retain_drop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_reg.st == ST_EXC |=> !ram_retain_o)
		else $error("retention flag kept after exception start");
endmodule : powerup_standby_reset_sequencer

// ===== test/supervisor_model.sv
`timescale 1ns/10ps
module supervisor_model (
	input wire logic mclk_i,
	output logic hw_standby_n_o,
	output logic nmi_o,
	output logic external_clear_n_o,
	output logic onchip_ram_enable_o
);
	initial begin
		hw_standby_n_o = 1'h0;
		nmi_o = 1'h0;
		external_clear_n_o = 1'h0;
		onchip_ram_enable_o = 1'h0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : step
	task automatic enter_standby(input logic keep);
		onchip_ram_enable_o = keep;
		if (keep) begin
			external_clear_n_o = 1'h0;
			step(12);
		end
		hw_standby_n_o = 1'h0;
		step(1);
		external_clear_n_o = 1'h1;
	endtask : enter_standby
	task automatic leave_standby();
		external_clear_n_o = 1'h0;
		nmi_o = 1'h1;
		step(2);
		hw_standby_n_o = 1'h1;
	endtask : leave_standby
endmodule : supervisor_model

// ===== test/powerup_standby_reset_sequencer_tb.sv
`timescale 1ns/10ps
module powerup_standby_reset_sequencer_tb;
	import pwr_seq_pkg::*;
`define check(a, b) begin tests_run++; if ((a) !== (b)) begin \
	fails++; $display("mismatch %0t %0h", $time, a); end end
	logic mclk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic hw_standby_n_n, nmi, clr_n, onchip_ram_enable, osc, hiz, undef, man, por, exc, keep;
	logic [2:0] state_o;
	int fails = 0;
	int tests_run = 0;
	always #50 mclk_i = ~mclk_i;
	supervisor_model sup (.mclk_i(mclk_i), .hw_standby_n_o(hw_standby_n_n),
		.nmi_o(nmi), .external_clear_n_o(clr_n), .onchip_ram_enable_o(onchip_ram_enable));
	powerup_standby_reset_sequencer uut (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.hw_standby_n_i(hw_standby_n_n), .nmi_i(nmi), .external_clear_n_i(clr_n),
		.onchip_ram_enable_i(onchip_ram_enable), .osc_enable_o(osc), .pins_hiz_o(hiz),
		.pins_undefined_o(undef), .manual_reset_o(man), .por_reset_o(por),
		.exc_start_o(exc), .ram_retain_o(keep), .state_o(state_o));
	task automatic close_out();
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic wait_state(input seq_state_t s);
		for (int n = 0; n < 20 && state_o !== s; n++) sup.step(1);
		`check(state_o, s)
	endtask : wait_state
	task automatic reset_check();
		sup.step(4);
		`check({man, undef}, 2'h3)
		nrst_i = 1'h1;
		wait_state(ST_STANDBY);
		`check({hiz, osc}, 2'h2)
	endtask : reset_check
	task automatic power_on();
		sup.leave_standby();
		`check(osc, 1'h0)
		wait_state(ST_POR);
		`check({osc, por, hiz}, 3'h6)
		sup.external_clear_n_o = 1'h1;
		wait_state(ST_EXC);
		`check(exc, 1'h1)
		sup.step(1);
		`check({state_o, exc, keep}, 5'h10)
	endtask : power_on
	task automatic standby_entry(input logic k);
		sup.enter_standby(k);
		wait_state(ST_STANDBY);
		`check({keep, hiz}, {k, 1'h1})
		power_on();
	endtask : standby_entry
	task automatic nmi_check();
		sup.nmi_o = 1'h0;
		nrst_i = 1'h0;
		sup.step(2);
		nrst_i = 1'h1;
		sup.step(8);
		`check({state_o, man, undef}, {ST_MANUAL, 2'h3})
		sup.nmi_o = 1'h1;
		wait_state(ST_POR);
		wait_state(ST_RUN);
	endtask : nmi_check
	task automatic glitch_check();
		sup.hw_standby_n_o = 1'h0;
		sup.step(1);
		sup.hw_standby_n_o = 1'h1;
		sup.step(8);
		`check(state_o, 3'h4)
	endtask : glitch_check
	initial begin
		#100000;
		fails++;
		close_out();
	end
	initial begin
		reset_check();
		power_on();
		standby_entry(1'h1);
		standby_entry(1'h0);
		nmi_check();
		glitch_check();
		close_out();
	end
endmodule : powerup_standby_reset_sequencer_tb
